// >>> psl_lamp_driver.sv
// Status lamp driver: strap capture of lamp polarity, then lamp drive.
// Assumes link status comes from logic on i_clk; lamp pins are board pins.
// Behaviour
// R1: lamp pins are straps at reset release, then drive their indicator.
// R2: pin low at reset release gives an active-high lamp drive.
// R3: pin high at reset release gives an active-low lamp drive.
// R4: standard mode lights separate 10M, 100M, link, duplex, tx, rx lamps.
// R5: advanced mode lights one of four speed/duplex lamps; link kept.
// R6: advanced speed/duplex lamp steady on when there is no activity.
// R7: advanced combined lamp blinks per duplex and rx-only config bit.
// R8: separate select blinks tx lamp on tx and rx lamp on rx.
// R9: in half duplex without rx-only config, tx and rx active together stops combined lamp blinking that packet.
// R10: blinking uses a slow fixed interval; activity is stretched visibly.
`timescale 1ns/10ps
module psl_lamp_driver
  import psl_pkg::*;
#(
  parameter int BLINK_CYCLES = BLINK_HALF_CYCLES
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_nrst,
  input  wire psl_link_status_t     i_status,
  input  wire logic                 i_advanced_mode,
  input  wire logic                 i_activity_rx_only_cfg,
  input  wire logic                 i_separate_activity_select,
  input  wire logic [NUM_LAMPS-1:0] i_lamp_pin,
  output logic      [NUM_LAMPS-1:0] o_lamp_pin,
  output logic      [NUM_LAMPS-1:0] o_lamp_oe_n
);

  psl_state_t             state;
  logic [2:0]             strap_cnt;
  logic [NUM_LAMPS-1:0]   sync1;
  logic [NUM_LAMPS-1:0]   sync2;
  logic [NUM_LAMPS-1:0]   sync3;
  logic [NUM_LAMPS-1:0]   pol;
  logic [31:0]            blink_cnt;
  logic                   tick;
  logic                   phase;
  logic                   tx_str;
  logic                   rx_str;
  logic                   tx_seen;
  logic                   rx_seen;
  logic                   both_seen;

  // Pin sampling, three flops per pin
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= i_lamp_pin;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Strap window: pins stay undriven until the sampled level is stable
  wire strap_stable = (sync2 == sync3);
  wire strap_done   = (state == PSL_ST_STRAP) &&
                      (strap_cnt == STRAP_CNT_LAST) && strap_stable;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state     <= PSL_ST_STRAP;
      strap_cnt <= '0;
      pol       <= POL_RST;
    end else if (state == PSL_ST_STRAP) begin
      if (strap_cnt != STRAP_CNT_LAST) begin
        strap_cnt <= strap_cnt + 3'h1;
      end
      if (strap_done) begin
        pol   <= sync3;                               // see R1
        state <= PSL_ST_DRIVE;
      end
    end
  end

  // Blink divider: one-cycle enable every half period
  wire blink_wrap = (blink_cnt == 32'(BLINK_CYCLES - 1));

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      blink_cnt <= '0;
      tick      <= 1'b0;
    end else begin
      blink_cnt <= blink_wrap ? '0 : blink_cnt + 32'h1;
      tick      <= blink_wrap;                        // see R10
    end
  end

  // Stretch: activity seen in one half period holds the lamp for the next
  wire tx_raw = i_status.tx_active;
  wire rx_raw = i_status.rx_active;
  wire any_str = tx_str | rx_str;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tx_str  <= 1'b0;
      rx_str  <= 1'b0;
      tx_seen <= 1'b0;
      rx_seen <= 1'b0;
      phase   <= 1'b0;
    end else begin
      // New activity wins over the end of a stretch period
      tx_seen <= tx_raw | (tx_seen & ~tick);
      rx_seen <= rx_raw | (rx_seen & ~tick);
      tx_str  <= tx_raw | (tick ? tx_seen : tx_str);  // see R10
      rx_str  <= rx_raw | (tick ? rx_seen : rx_str);  // see R10
      if (!any_str) begin
        phase <= 1'b0;
      end else if (tick) begin
        phase <= ~phase;                              // see R10
      end
    end
  end

  // Cleared only once both directions fall idle
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      both_seen <= 1'b0;
    end else begin
      both_seen <= (tx_raw & rx_raw) |
                   (both_seen & (tx_raw | rx_raw));   // see R9
    end
  end

  // Lamp decode, active-high "lit" view
  wire link = i_status.link_up;
  wire s100 = i_status.speed_100;
  wire fdx  = i_status.full_duplex;
  wire adv  = i_advanced_mode;
  wire sep  = i_separate_activity_select;

  wire combined_src = fdx ? rx_str :                              // see R7
                      (i_activity_rx_only_cfg ? rx_str : any_str);
  wire combined_hold = ~fdx & ~i_activity_rx_only_cfg & both_seen; // see R9
  wire combined_dark = ~sep & combined_src & phase &
                       ~combined_hold;                             // see R6
  wire quad_on = link & ~combined_dark;

  wire [NUM_LAMPS-1:0] lit_std;
  wire [NUM_LAMPS-1:0] lit_adv;

  assign lit_std[TEN_MEG_SPEED_LAMP]     = link & ~s100;          // see R4
  assign lit_std[HUNDRED_MEG_SPEED_LAMP] = link & s100;           // see R4
  assign lit_std[LINK_UP_LAMP]           = link;                  // see R4
  assign lit_std[FULL_DUPLEX_LAMP]       = link & fdx;            // see R4
  assign lit_std[TRANSMIT_ACTIVITY_LAMP] = tx_str;                // see R4
  assign lit_std[RECEIVE_ACTIVITY_LAMP]  = rx_str;                // see R4
  assign lit_std[TEN_HALF_LAMP]          = 1'b0;
  assign lit_std[TEN_FULL_LAMP]          = 1'b0;
  assign lit_std[HUNDRED_HALF_LAMP]      = 1'b0;
  assign lit_std[HUNDRED_FULL_LAMP]      = 1'b0;

  // Without separate select there is no tx-only lamp in advanced mode
  assign lit_adv[TEN_MEG_SPEED_LAMP]     = 1'b0;
  assign lit_adv[HUNDRED_MEG_SPEED_LAMP] = 1'b0;
  assign lit_adv[LINK_UP_LAMP]           = link;                  // see R5
  assign lit_adv[FULL_DUPLEX_LAMP]       = 1'b0;
  assign lit_adv[TRANSMIT_ACTIVITY_LAMP] = sep & tx_str & ~phase; // see R8
  assign lit_adv[RECEIVE_ACTIVITY_LAMP]  = sep & rx_str & ~phase; // see R8
  assign lit_adv[TEN_HALF_LAMP]          = quad_on & ~s100 & ~fdx; // see R5
  assign lit_adv[TEN_FULL_LAMP]          = quad_on & ~s100 & fdx;  // see R5
  assign lit_adv[HUNDRED_HALF_LAMP]      = quad_on & s100 & ~fdx;  // see R5
  assign lit_adv[HUNDRED_FULL_LAMP]      = quad_on & s100 & fdx;   // see R5

  wire [NUM_LAMPS-1:0] lit = adv ? lit_adv : lit_std;

  // Per-pin drive; pins float during the strap window so straps win
  genvar g;
  generate
    for (g = 0; g < NUM_LAMPS; g++) begin : g_pin
      wire drive_level = lit[g] ^ pol[g];           // see R2, R3
      always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          o_lamp_pin[g]  <= LAMP_RST[g];
          o_lamp_oe_n[g] <= OE_N_RST[g];
        end else begin
          o_lamp_pin[g]  <= (state == PSL_ST_DRIVE) ? drive_level
                                                      : LAMP_RST[g];
          o_lamp_oe_n[g] <= (state != PSL_ST_DRIVE); // see R1
        end
      end
    end
  endgenerate

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  wire driving = (state == PSL_ST_DRIVE);
  wire [NUM_LAMPS-1:0] pin_lit = o_lamp_pin ^ pol;
  wire [3:0] quad_lit = pin_lit[HUNDRED_FULL_LAMP:TEN_HALF_LAMP];
  logic [31:0] tick_gap;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tick_gap <= '0;
    end else begin
      tick_gap <= tick ? 32'h0 : tick_gap + 32'h1;
    end
  end

  sequence s_settle;
    (state == PSL_ST_STRAP) ##1 driving;
  endsequence

  strap_float_a: assert property ( // see R1
    !driving |=> o_lamp_oe_n == OE_N_RST
  ) else $error("Lamp pin driven during strap window");

  drive_start_a: assert property ( // see R1
    s_settle |=> o_lamp_oe_n == '0 && pol == $past(sync3, 2)
  ) else $error("Lamp drive not enabled after strap");

  pol_high_a: assert property ( // see R2
    driving && !pol[LINK_UP_LAMP] && link |=> o_lamp_pin[LINK_UP_LAMP]
  ) else $error("Active-high link lamp not high");

  pol_low_a: assert property ( // see R3
    driving && pol[LINK_UP_LAMP] && link |=> !o_lamp_pin[LINK_UP_LAMP]
  ) else $error("Active-low link lamp not low");

  std_speed_a: assert property ( // see R4
    driving && !adv && link && s100 |=>
      pin_lit[HUNDRED_MEG_SPEED_LAMP] && !pin_lit[TEN_MEG_SPEED_LAMP]
  ) else $error("Standard speed lamps wrong");

  // Select taken with its cause, so a select change cannot misfire
  adv_onehot_a: assert property ( // see R5
    driving && adv |=> $onehot0(quad_lit) &&
      pin_lit[TRANSMIT_ACTIVITY_LAMP] == $past(sep & tx_str & ~phase)
  ) else $error("Advanced lamps not one-hot");

  adv_steady_a: assert property ( // see R6
    driving && adv && link && !tx_str && !rx_str |=> $onehot(quad_lit)
  ) else $error("Idle speed lamp not steady");

  fdx_rx_only_a: assert property ( // see R7
    driving && adv && !sep && link && fdx && !rx_str |=> $onehot(quad_lit)
  ) else $error("Full duplex lamp blinked on tx");

  sep_tx_a: assert property ( // see R8
    driving && adv && sep && !tx_str |=> !pin_lit[TRANSMIT_ACTIVITY_LAMP]
  ) else $error("Tx lamp lit without activity");

  sep_rx_a: assert property ( // see R8
    driving && adv && sep && !rx_str |=> !pin_lit[RECEIVE_ACTIVITY_LAMP]
  ) else $error("Rx lamp lit without activity");

  both_hold_a: assert property ( // see R9
    driving && adv && !sep && link && !fdx && both_seen &&
      !i_activity_rx_only_cfg |=> $onehot(quad_lit)
  ) else $error("Combined lamp blinked with tx and rx");

  blink_rate_a: assert property ( // see R10
    $changed(phase) && phase |-> $past(tick) && $past(tick_gap) != 32'h0
  ) else $error("Blink phase moved off the divider");

  stretch_a: assert property ( // see R10
    $rose(tx_raw) |=> tx_str [*2]
  ) else $error("Activity not stretched");

endmodule

// >>> psl_pkg.sv
// Package for the status lamp driver: pin indices, timing, status carrier.
// Assumes a single 125 MHz clock shared with the link status logic.
package psl_pkg;

  localparam int NUM_LAMPS = 10;

  // Lamp pin positions in the pin vectors
  localparam int TEN_MEG_SPEED_LAMP     = 0;
  localparam int HUNDRED_MEG_SPEED_LAMP = 1;
  localparam int LINK_UP_LAMP           = 2;
  localparam int FULL_DUPLEX_LAMP       = 3;
  localparam int TRANSMIT_ACTIVITY_LAMP = 4;
  localparam int RECEIVE_ACTIVITY_LAMP  = 5;
  localparam int TEN_HALF_LAMP          = 6;
  localparam int TEN_FULL_LAMP          = 7;
  localparam int HUNDRED_HALF_LAMP      = 8;
  localparam int HUNDRED_FULL_LAMP      = 9;

  // Timing
  localparam int CLK_PERIOD_NS       = 8;
  localparam int BLINK_HALF_NS       = 50_000_000;
  localparam int BLINK_HALF_CYCLES   = BLINK_HALF_NS / CLK_PERIOD_NS;
  localparam int STRAP_SETTLE_CYCLES = 4;
  localparam logic [2:0] STRAP_CNT_LAST = 3'(STRAP_SETTLE_CYCLES - 1);

  // Values after reset
  localparam logic [NUM_LAMPS-1:0] LAMP_RST   = '0;
  localparam logic [NUM_LAMPS-1:0] OE_N_RST   = '1;
  localparam logic [NUM_LAMPS-1:0] POL_RST    = '0;

  typedef enum logic {
    PSL_ST_STRAP,
    PSL_ST_DRIVE
  } psl_state_t;

  typedef struct packed {
    logic link_up;
    logic speed_100;
    logic full_duplex;
    logic tx_active;
    logic rx_active;
  } psl_link_status_t;

endpackage

// >>> psl_board_model.sv
// Board model: strap resistor on each lamp pin, plus lamp decode.
// Assumes straps change only while the lamp driver is held in reset.
`timescale 1ns/10ps
module psl_board_model
  import psl_pkg::*;
(
  input  wire logic [NUM_LAMPS-1:0] i_strap,
  input  wire logic [NUM_LAMPS-1:0] i_drive_level,
  input  wire logic [NUM_LAMPS-1:0] i_drive_oe_n,
  output logic      [NUM_LAMPS-1:0] o_pin,
  output logic      [NUM_LAMPS-1:0] o_lit
);
  // Released pin falls to its resistor, never a stale drive level
  assign o_pin = (~i_drive_oe_n & i_drive_level) | (i_drive_oe_n & i_strap);
  // Undriven lamp is dark whatever its strap
  assign o_lit = ~i_drive_oe_n & (i_drive_level ^ i_strap);
endmodule

// >>> phy_status_led_driver_tb.sv
// Self-checking bench for the status lamp driver with a board model.
// Assumes a shortened blink interval so blink phases show in a few cycles.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin \
  cmp_count++; \
  if ((got) !== (ex)) begin \
    mismatches++; \
    $display("unexpected %s expected %0h seen %0h", nm, ex, got); \
  end \
end
module phy_status_led_driver_tb;
  import psl_pkg::*;
  logic                 i_clk  = 1'b0;
  logic                 i_nrst = 1'b0;
  psl_link_status_t     st     = '0;
  logic                 adv    = 1'b0;
  logic                 cfg    = 1'b0;
  logic                 sep    = 1'b0;
  logic [NUM_LAMPS-1:0] strap  = '0;
  logic [NUM_LAMPS-1:0] pin_in;
  logic [NUM_LAMPS-1:0] lamp_pin;
  logic [NUM_LAMPS-1:0] lamp_oe_n;
  logic [NUM_LAMPS-1:0] lit;
  logic [31:0]          r;
  int                   mismatches = 0;
  int                   cmp_count  = 0;

  always #4 i_clk = ~i_clk;

  psl_lamp_driver #(.BLINK_CYCLES(8)) dut (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_status(st), .i_advanced_mode(adv),
    .i_activity_rx_only_cfg(cfg), .i_separate_activity_select(sep),
    .i_lamp_pin(pin_in), .o_lamp_pin(lamp_pin), .o_lamp_oe_n(lamp_oe_n));

  psl_board_model board (.i_strap(strap), .i_drive_level(lamp_pin),
    .i_drive_oe_n(lamp_oe_n), .o_pin(pin_in), .o_lit(lit));

  function automatic logic [NUM_LAMPS-1:0] steady(input logic a,
      input logic s100, input logic fd);
    logic [NUM_LAMPS-1:0] e;
    e = '0;
    e[LINK_UP_LAMP] = 1'b1;
    if (a) begin
      e[TEN_HALF_LAMP + 2 * int'(s100) + int'(fd)] = 1'b1;
    end else begin
      e[TEN_MEG_SPEED_LAMP] = ~s100;
      e[HUNDRED_MEG_SPEED_LAMP] = s100;
      e[FULL_DUPLEX_LAMP] = fd;
    end
    return e;
  endfunction

  task automatic final_report();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic do_reset(input logic [NUM_LAMPS-1:0] s);
    @(posedge i_clk);
    i_nrst <= 1'b0;
    strap <= s;
    repeat (16) @(posedge i_clk);
    #1;
    `CHK("oe_n in reset", {NUM_LAMPS{1'b1}}, lamp_oe_n)
    @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (10) @(posedge i_clk);
    #1;
    `CHK("oe_n driving", {NUM_LAMPS{1'b0}}, lamp_oe_n)
  endtask

  task automatic set_in(input logic a, input logic c, input logic sp,
      input logic s100, input logic fd, input logic tx, input logic rx);
    @(posedge i_clk);
    adv <= a;
    cfg <= c;
    sep <= sp;
    st <= '{1'b1, s100, fd, tx, rx};
    repeat (3) @(posedge i_clk);
    #1;
  endtask

  task automatic act_chk(input logic s100, input logic fd, input logic c,
      input logic sp, input logic [1:0] act);
    int   dark;
    int   txl;
    int   rxl;
    int   q;
    logic eb;
    q = TEN_HALF_LAMP + 2 * int'(s100) + int'(fd);
    dark = 0;
    txl = 0;
    rxl = 0;
    set_in(1'b1, c, sp, s100, fd, act[1], act[0]);
    repeat (36) begin
      @(posedge i_clk);
      #1;
      dark += int'(lit[q] === 1'b0);
      txl += int'(lit[TRANSMIT_ACTIVITY_LAMP] === 1'b1);
      rxl += int'(lit[RECEIVE_ACTIVITY_LAMP] === 1'b1);
    end
    eb = ~sp & ((fd | c) ? act[0] : (act != 2'b11));
    `CHK("combined blink", eb, dark > 0)
    `CHK("combined lit", 1'b1, dark < 36)
    `CHK("tx lamp blink", sp & act[1], txl > 0 && txl < 36)
    `CHK("rx lamp blink", sp & act[0], rxl > 0 && rxl < 36)
    set_in(1'b1, c, sp, s100, fd, 1'b0, 1'b0);
    repeat (40) @(posedge i_clk);
  endtask

  initial begin
    repeat (20000) @(posedge i_clk);
    mismatches++;
    final_report();
  end

  initial begin
    void'($urandom(4752));
    r = $urandom;
    do_reset(r[NUM_LAMPS-1:0]);
    for (int i = 0; i < 24; i++) begin
      r = $urandom;
      set_in(r[0], r[1], r[2], r[3], r[4], 1'b0, 1'b0);
      `CHK("steady lamps", steady(r[0], r[3], r[4]), lit)
    end
    @(posedge i_clk);
    adv <= 1'b0;
    st <= '0;
    repeat (3) @(posedge i_clk);
    #1;
    `CHK("link lamp off", 1'b0, lit[LINK_UP_LAMP])
    set_in(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
    `CHK("std tx lamp", 1'b1, lit[TRANSMIT_ACTIVITY_LAMP])
    `CHK("std rx lamp", 1'b1, lit[RECEIVE_ACTIVITY_LAMP])
    set_in(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    repeat (40) @(posedge i_clk);
    for (int k = 0; k < 16; k++) begin
      for (int a = 1; a < 4; a++) begin
        act_chk(k[0], k[1], k[2], k[3], a[1:0]);
      end
    end
    do_reset(~strap);
    for (int i = 0; i < 8; i++) begin
      r = $urandom;
      set_in(r[0], r[1], r[2], r[3], r[4], 1'b0, 1'b0);
      `CHK("steady lamps", steady(r[0], r[3], r[4]), lit)
    end
    final_report();
  end
endmodule
